// [pbp_core.sv]
// pulse detection, baseline averaging and peak capture core
//
// The implementer's own choices: the register offsets and the strobed register port.
module pbp_core #(
	parameter int HIST_AW = 10
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic [pbp_pkg::ADC_W-1:0] adc_data,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic event_valid,
	output logic signed [31:0] event_energy,
	output logic bl_hist_valid,
	output logic signed [31:0] bl_hist_value,
	output logic busy
);
	import pbp_pkg::*;
	typedef struct packed {
		logic [1:0] dec;
		logic fast_en;
		logic inter_en;
		logic slow_en;
		logic signed [31:0] fast_thr;
		logic signed [31:0] inter_thr;
		logic signed [31:0] slow_thr;
		logic [7:0] fast_len;
		logic [7:0] fast_gap;
		logic [7:0] slow_len;
		logic [7:0] slow_gap;
		logic [7:0] peak_int;
		logic [7:0] peak_sam;
		logic [15:0] bl_div;
		logic signed [31:0] bl_center;
		logic [15:0] cut_minus;
		logic [15:0] cut_plus;
		logic [15:0] bl_period;
		logic [HIST_AW-1:0] wp;
		logic signed [31:0] fast_v;
		logic signed [31:0] inter_v;
		logic signed [31:0] slow_v;
		pbp_state_t st;
		logic [7:0] tmr;
		logic signed [31:0] peak;
		logic signed [31:0] energy;
		logic [15:0] ev_cnt;
		logic ev_valid;
		logic bsy;
		logic signed [47:0] bl_acc;
		logic [15:0] bl_n;
		logic [15:0] bl_tmr;
		logic bl_ready;
		logic hv;
		logic signed [31:0] hval;
		logic [31:0] rdata;
	} pbp_core_st_t;
	localparam pbp_core_st_t S_RST = '{
		dec: R_DEC,
		fast_en: R_FAST_EN,
		inter_en: R_INTER_EN,
		slow_en: R_SLOW_EN,
		fast_thr: R_FAST_THR,
		inter_thr: R_INTER_THR,
		slow_thr: R_SLOW_THR,
		fast_len: R_FAST_LEN,
		fast_gap: R_FAST_GAP,
		slow_len: R_SLOW_LEN,
		slow_gap: R_SLOW_GAP,
		peak_int: R_PEAK_INT,
		peak_sam: R_PEAK_SAM,
		bl_div: R_BL_DIV,
		cut_minus: R_CUT,
		cut_plus: R_CUT,
		bl_period: R_BL_PERIOD,
		st: ST_IDLE,
		default: '0
	};
	pbp_core_st_t s;
	pbp_core_st_t n;
	logic [ADC_W-1:0] hist [2**HIST_AW];
	logic dv;
	logic [ADC_W-1:0] dsmp;
	logic signed [31:0] avg;
	logic inter_ok;
	logic fast_hit;
	logic inter_hit;
	logic slow_hit;
	logic trig;
	logic quiet;
	logic take;
	logic in_cut;
	logic [7:0] inter_len;
	logic signed [31:0] cut_lo;
	logic signed [31:0] cut_hi;
	logic signed [32:0] diff;
	logic signed [49:0] prod;
	logic [31:0] prod_n;

	// zero-extend an adc sample to the filter width
	function automatic logic signed [31:0] ext(input logic [ADC_W-1:0] x);
		return $signed({{(32 - ADC_W){1'b0}}, x});
	endfunction : ext

	// history index k decimated samples back from the write slot
	function automatic logic [HIST_AW-1:0] tap(
		input logic [HIST_AW-1:0] wp,
		input logic [9:0] k
	);
		return wp - HIST_AW'(k);
	endfunction : tap

	// one recursive trapezoid step with length l and gap g
	function automatic logic signed [31:0] filt(
		input logic signed [31:0] v,
		input logic [ADC_W-1:0] x0,
		input logic [7:0] l,
		input logic [7:0] g
	);
		logic [9:0] a;
		logic [9:0] b;
		logic [9:0] c;
		a = {2'h0, l};
		b = a + {2'h0, g};
		c = b + a;
		return v + ext(x0) - ext(hist[tap(s.wp, a)])
			- ext(hist[tap(s.wp, b)]) + ext(hist[tap(s.wp, c)]);
	endfunction : filt

	pbp_decim u_decim (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.dec(s.dec),
		.adc_data(adc_data),
		.smp_valid(dv),
		.smp_data(dsmp)
	);

	// threshold comparators and trigger
	assign inter_ok = s.dec != DEC0;
	assign fast_hit = s.fast_en && (s.fast_v > s.fast_thr);
	assign inter_hit = inter_ok && s.inter_en && (s.inter_v > s.inter_thr);
	assign slow_hit = s.slow_en && (s.slow_v > s.slow_thr);
	assign trig = fast_hit || inter_hit || slow_hit;
	assign inter_len = (s.slow_len[7:1] == 7'h00) ? 8'h01
		: {1'b0, s.slow_len[7:1]};

	// baseline eligibility, cut window and running average arithmetic
	assign avg = s.bl_acc[BL_FRAC +: 32];
	assign quiet = (s.st == ST_IDLE) && !trig && (inter_ok
		? (s.inter_v < s.inter_thr) : (s.fast_v < s.fast_thr));
	assign take = dv && quiet && (!s.bl_ready
		|| (s.bl_tmr >= s.bl_period));
	assign cut_lo = s.bl_center - $signed({16'h0000, s.cut_minus});
	assign cut_hi = s.bl_center + $signed({16'h0000, s.cut_plus});
	assign in_cut = (s.slow_v >= cut_lo) && (s.slow_v <= cut_hi);
	assign diff = {s.slow_v[31], s.slow_v} - {avg[31], avg};
	assign prod = diff * $signed({1'b0, s.bl_div});
	assign prod_n = {16'h0000, s.bl_n + 16'h0001} * {16'h0000, s.bl_div};

	// next state: filters, event machine, baseline and register port
	always_comb begin
		n = s;
		n.ev_valid = 1'b0;
		n.hv = 1'b0;
		n.rdata = 32'h0000_0000;
		if (dv) begin
			n.wp = s.wp + HIST_AW'(1);
			n.fast_v = filt(s.fast_v, dsmp, s.fast_len, s.fast_gap);
			n.slow_v = filt(s.slow_v, dsmp, s.slow_len, s.slow_gap);
			n.inter_v = inter_ok ? filt(s.inter_v, dsmp, inter_len, s.slow_gap)
				: '0;
			case (s.st)
				ST_IDLE: begin
					if (trig) begin
						n.tmr = 8'h01;
						n.peak = 32'sh8000_0000;
						n.st = (s.dec == DEC0) ? ST_SAMPLE : ST_FIND;
					end
				end
				ST_FIND: begin
					n.tmr = s.tmr + 8'h01;
					if (s.tmr >= s.slow_len && s.tmr < s.peak_int
						&& s.slow_v > s.peak) begin
						n.peak = s.slow_v;
					end
					if (s.tmr >= s.peak_int) begin
						n.energy = s.peak - avg;
						n.ev_valid = 1'b1;
						n.ev_cnt = s.ev_cnt + 16'h0001;
						n.st = ST_IDLE;
					end
				end
				ST_SAMPLE: begin
					n.tmr = s.tmr + 8'h01;
					if (s.tmr >= s.peak_sam) begin
						n.energy = s.slow_v - avg;
						n.ev_valid = 1'b1;
						n.ev_cnt = s.ev_cnt + 16'h0001;
						n.st = ST_DONE;
					end
				end
				ST_DONE: begin
					n.tmr = s.tmr + 8'h01;
					if (s.tmr >= s.peak_int) begin
						n.st = ST_IDLE;
					end
				end
				default: begin
					n.st = ST_IDLE;
				end
			endcase
			if (take) begin
				n.hv = 1'b1;
				n.hval = s.slow_v;
				n.bl_tmr = 16'h0000;
				if (in_cut) begin
					n.bl_acc = (s.bl_n == 16'h0000)
						? {s.slow_v[31], s.slow_v, 15'h0000}
						: s.bl_acc + prod[47:0];
					if (!s.bl_ready) begin
						n.bl_n = s.bl_n + 16'h0001;
						n.bl_ready = prod_n >= BL_FULL;
					end
				end
			end else if (s.bl_ready && s.bl_tmr != 16'hffff) begin
				n.bl_tmr = s.bl_tmr + 16'h0001;
			end
		end
		n.bsy = n.st != ST_IDLE; // busy port comes straight from a flop
		if (reg_wr) begin
			case (reg_addr)
				A_CTRL: begin
					n.dec = reg_wdata[F_DEC +: 2];
					n.fast_en = reg_wdata[F_FAST_EN];
					n.inter_en = reg_wdata[F_INTER_EN];
					n.slow_en = reg_wdata[F_SLOW_EN];
				end
				A_FAST_THR: n.fast_thr = reg_wdata;
				A_INTER_THR: n.inter_thr = reg_wdata;
				A_SLOW_THR: n.slow_thr = reg_wdata;
				A_FAST_FILT: begin
					n.fast_len = reg_wdata[F_LEN +: 8];
					n.fast_gap = reg_wdata[F_GAP +: 8];
				end
				A_ENERGY_FILT: begin
					n.slow_len = reg_wdata[F_LEN +: 8];
					n.slow_gap = reg_wdata[F_GAP +: 8];
				end
				A_PEAK: begin
					n.peak_int = reg_wdata[F_PINT +: 8];
					n.peak_sam = reg_wdata[F_PSAM +: 8];
				end
				A_BL_DIV: n.bl_div = reg_wdata[15:0];
				A_BL_CENTER: n.bl_center = reg_wdata;
				A_BL_CUT: begin
					n.cut_minus = reg_wdata[F_CUTM +: 16];
					n.cut_plus = reg_wdata[F_CUTP +: 16];
				end
				A_BL_PERIOD: n.bl_period = reg_wdata[15:0];
				default: begin
				end
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				A_CTRL: begin
					n.rdata[F_DEC +: 2] = s.dec;
					n.rdata[F_FAST_EN] = s.fast_en;
					n.rdata[F_INTER_EN] = s.inter_en;
					n.rdata[F_SLOW_EN] = s.slow_en;
				end
				A_FAST_THR: n.rdata = s.fast_thr;
				A_INTER_THR: n.rdata = s.inter_thr;
				A_SLOW_THR: n.rdata = s.slow_thr;
				A_FAST_FILT: n.rdata = {16'h0000, s.fast_gap, s.fast_len};
				A_ENERGY_FILT: n.rdata = {16'h0000, s.slow_gap, s.slow_len};
				A_PEAK: n.rdata = {16'h0000, s.peak_sam, s.peak_int};
				A_BL_DIV: n.rdata = {16'h0000, s.bl_div};
				A_BL_CENTER: n.rdata = s.bl_center;
				A_BL_CUT: n.rdata = {s.cut_plus, s.cut_minus};
				A_BL_PERIOD: n.rdata = {16'h0000, s.bl_period};
				A_ENERGY: n.rdata = s.energy;
				A_BL_AVG: n.rdata = avg;
				A_STATUS: begin
					n.rdata[F_CNT +: 16] = s.ev_cnt;
					n.rdata[F_BUSY] = s.st != ST_IDLE;
					n.rdata[F_BLRDY] = s.bl_ready;
				end
				default: n.rdata = 32'h0000_0000;
			endcase
		end
	end

	// state register, frozen while ce is low
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s <= S_RST;
		end else if (ce) begin
			s <= n;
		end
	end

	// decimated sample history for the filter taps
	always_ff @(posedge clk_sys) begin
		if (ce && dv) begin
			hist[s.wp] <= dsmp;
		end
	end

	// outputs straight from the state register
	assign reg_rdata = s.rdata;
	assign event_valid = s.ev_valid;
	assign event_energy = s.energy;
	assign bl_hist_valid = s.hv;
	assign bl_hist_value = s.hval;
	assign busy = s.bsy;

	// checks on the event machine and baseline logic
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	sequence q_trig_idle;
		ce && dv && s.st == ST_IDLE && trig;
	endsequence
	sequence q_sample_due;
		ce && dv && s.st == ST_SAMPLE && s.tmr >= s.peak_sam;
	endsequence

	a_trig_start: assert property (q_trig_idle |=> busy)
		else $error("trigger did not start event");
	a_dec0_sample: assert property (
		q_trig_idle ##0 s.dec == DEC0 |=> s.st == ST_SAMPLE)
		else $error("decimation 0 not in sampling mode");
	a_sample_out: assert property (q_sample_due |=> event_valid
		&& event_energy == $past(s.slow_v) - $past(avg))
		else $error("fixed delay sample wrong");
	a_find_out: assert property (
		ce && dv && s.st == ST_FIND && s.tmr >= s.peak_int
		|=> event_valid && event_energy == $past(s.peak) - $past(avg))
		else $error("max capture result wrong");
	a_find_window: assert property (
		ce && dv && s.st == ST_FIND
		&& (s.tmr < s.slow_len || s.tmr >= s.peak_int)
		|=> s.peak == $past(s.peak))
		else $error("peak updated outside window");
	a_inter_off: assert property (s.dec == DEC0 |-> !inter_hit)
		else $error("intermediate active in decimation 0");
	a_inter_dflt: assert property ($past(rst) |-> s.inter_en)
		else $error("intermediate threshold not enabled");
	a_bl_quiet: assert property (
		take && inter_ok |-> s.inter_v < s.inter_thr)
		else $error("baseline taken above threshold");
	a_bl_cut: assert property (ce && take && !in_cut
		|=> s.bl_acc == $past(s.bl_acc) && bl_hist_valid)
		else $error("cut sample reached average");
	a_bl_ready: assert property (
		$rose(s.bl_ready) |-> $past(prod_n) >= BL_FULL)
		else $error("initial baseline count wrong");
endmodule : pbp_core

// [pbp_pkg.sv]
// constants and types for the pulse baseline and peak capture core
// How it works
// - baseline average weight is divisor/32768, so 32768/divisor samples
// - energy equals captured slow filter value minus baseline average
// - baseline samples outside cut window skip average, still go to histogram
// - fast, intermediate and slow filters each own an enabled comparator
// - fast threshold crossing starts an event, never gives the energy
// - intermediate filter exists only in decimation 2, 4 and 6
// - baseline taken only while intermediate output (fast output in decimation 0) is below its threshold
// - intermediate threshold crossing also starts an event
// - intermediate threshold comes out of reset enabled
// - after detection the step height comes from the slow filter
// - decimation 2, 4, 6 capture the largest slow value in a window
// - capture window built only from filter length and peak interval
// - decimation 0 samples slow output once, fixed delay after trigger
// - energy gap is a setting separate from energy length
// - peak timer expires after peak interval decimated cycles
// - after initial mean, baseline refreshed at periodic intervals
package pbp_pkg;
	localparam int ADC_W = 14;
	localparam int BL_FRAC = 15;
	localparam logic [31:0] BL_FULL = 32'h0000_8000;
	// register indexes
	localparam logic [3:0] A_CTRL = 4'h0;
	localparam logic [3:0] A_FAST_THR = 4'h1;
	localparam logic [3:0] A_INTER_THR = 4'h2;
	localparam logic [3:0] A_SLOW_THR = 4'h3;
	localparam logic [3:0] A_FAST_FILT = 4'h4;
	localparam logic [3:0] A_ENERGY_FILT = 4'h5;
	localparam logic [3:0] A_PEAK = 4'h6;
	localparam logic [3:0] A_BL_DIV = 4'h7;
	localparam logic [3:0] A_BL_CENTER = 4'h8;
	localparam logic [3:0] A_BL_CUT = 4'h9;
	localparam logic [3:0] A_BL_PERIOD = 4'ha;
	localparam logic [3:0] A_ENERGY = 4'hb;
	localparam logic [3:0] A_BL_AVG = 4'hc;
	localparam logic [3:0] A_STATUS = 4'hd;
	// field positions
	localparam int F_DEC = 0;
	localparam int F_FAST_EN = 4;
	localparam int F_INTER_EN = 5;
	localparam int F_SLOW_EN = 6;
	localparam int F_LEN = 0;
	localparam int F_GAP = 8;
	localparam int F_PINT = 0;
	localparam int F_PSAM = 8;
	localparam int F_CUTM = 0;
	localparam int F_CUTP = 16;
	localparam int F_CNT = 0;
	localparam int F_BUSY = 16;
	localparam int F_BLRDY = 17;
	// decimation codes
	localparam logic [1:0] DEC0 = 2'h0;
	localparam logic [1:0] DEC2 = 2'h1;
	// reset values
	localparam logic [1:0] R_DEC = 2'h0;
	localparam logic R_FAST_EN = 1'b1;
	localparam logic R_INTER_EN = 1'b1;
	localparam logic R_SLOW_EN = 1'b0;
	localparam logic [31:0] R_FAST_THR = 32'h0000_0200;
	localparam logic [31:0] R_INTER_THR = 32'h0000_0080;
	localparam logic [31:0] R_SLOW_THR = 32'h0000_0040;
	localparam logic [7:0] R_FAST_LEN = 8'h04;
	localparam logic [7:0] R_FAST_GAP = 8'h00;
	localparam logic [7:0] R_SLOW_LEN = 8'h10;
	localparam logic [7:0] R_SLOW_GAP = 8'h04;
	localparam logic [7:0] R_PEAK_INT = 8'h20;
	localparam logic [7:0] R_PEAK_SAM = 8'h12;
	localparam logic [15:0] R_BL_DIV = 16'h0200;
	localparam logic [15:0] R_CUT = 16'h0100;
	localparam logic [15:0] R_BL_PERIOD = 16'h0040;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_FIND = 4'b0010,
		ST_SAMPLE = 4'b0100,
		ST_DONE = 4'b1000
	} pbp_state_t;
endpackage : pbp_pkg

// [pbp_decim.sv]
// decimator that averages 2^N adc samples into one decimated sample
module pbp_decim (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic [1:0] dec,
	input wire logic [pbp_pkg::ADC_W-1:0] adc_data,
	output logic smp_valid,
	output logic [pbp_pkg::ADC_W-1:0] smp_data
);
	import pbp_pkg::*;
	typedef struct packed {
		logic [ADC_W+5:0] sum;
		logic [5:0] cnt;
		logic v;
		logic [ADC_W-1:0] d;
	} pbp_dec_st_t;
	pbp_dec_st_t s;
	pbp_dec_st_t n;
	logic [2:0] sh;
	logic [5:0] lim;
	logic [ADC_W+5:0] acc;
	// shift 0, 2, 4, 6 from the decimation code
	assign sh = {dec, 1'b0};
	assign lim = 6'((7'h01 << sh) - 7'h01);
	assign acc = s.sum + {6'h00, adc_data};
	// accumulate and emit the mean every 2^N samples
	always_comb begin
		n = s;
		n.v = 1'b0;
		if (s.cnt >= lim) begin
			n.d = ADC_W'(acc >> sh);
			n.v = 1'b1;
			n.sum = '0;
			n.cnt = 6'h00;
		end else begin
			n.sum = acc;
			n.cnt = s.cnt + 6'h01;
		end
	end
	// state register, frozen while ce is low
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else if (ce) begin
			s <= n;
		end
	end
	assign smp_valid = s.v;
	assign smp_data = s.d;
	a_dec_emit: assert property (@(posedge clk_sys) disable iff (rst)
		ce && s.cnt >= lim |=> s.v)
		else $error("decimated sample not emitted");
	a_dec_restart: assert property (@(posedge clk_sys) disable iff (rst)
		s.v |-> s.cnt == 6'h00 && s.sum == '0)
		else $error("decimator did not restart");
endmodule : pbp_decim

// [pbp_adc_model.sv]
// behavioural adc digitising a preamplifier output: held level or ramp
module pbp_adc_model (
	input wire logic clk_sys,
	input wire logic ramp,
	input wire logic [pbp_pkg::ADC_W-1:0] level,
	output logic [pbp_pkg::ADC_W-1:0] adc_data
);
	timeunit 1ns;
	timeprecision 1ps;
	// one sample per clock; the ramp mimics detector leakage current
	always @(posedge clk_sys) begin
		adc_data <= ramp ? adc_data + 14'h1 : level;
	end
endmodule : pbp_adc_model

// [pbp_core_bench.sv]
// self-checking bench for the pulse baseline and peak capture core
module pbp_core_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import pbp_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic ramp = 1'b0;
	logic [ADC_W-1:0] level = 14'h1000;
	logic [ADC_W-1:0] adc_data;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic event_valid, bl_hist_valid, busy;
	logic signed [31:0] event_energy, bl_hist_value;
	int error_cnt = 0;
	int checked = 0;
	int cyc = 0;
	int bl_cnt = 0;
	int t_b, lo, hi, f;
	logic rd_seen = 1'b0;
	logic busy_q = 1'b0;
	logic armed = 1'b0;
	logic hist_zero = 1'b0;
	logic dur_chk = 1'b1;
	logic [7:0] pint = R_PEAK_INT;
	logic [7:0] psd;
	logic [31:0] d;
	logic [31:0] rd_q[$];
	int lo_q[$];
	int hi_q[$];
	logic [31:0] rst_tab [11] = '{32'h30, R_FAST_THR, R_INTER_THR,
		R_SLOW_THR, 32'h0004, 32'h0410, 32'h1220, 32'h0200, 32'h0,
		32'h01000100, 32'hffff};

	// 20 mhz system clock
	initial begin
		forever #25 clk_sys = ~clk_sys;
	end

	pbp_adc_model adc (
		.clk_sys(clk_sys),
		.ramp(ramp),
		.level(level),
		.adc_data(adc_data)
	);

	pbp_core #(.HIST_AW(10)) uut (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.adc_data(adc_data),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.event_valid(event_valid),
		.event_energy(event_energy),
		.bl_hist_valid(bl_hist_valid),
		.bl_hist_value(bl_hist_value),
		.busy(busy)
	);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t saw %h exp %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(posedge clk_sys);
	endtask : wr

	// the expected answer is queued before the strobe goes out
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(posedge clk_sys);
	endtask : rd

	task automatic clks(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : clks

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_of_test

	// cycle counter and hang guard
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			error_cnt++;
			end_of_test();
		end
	end

	// read answers stand only in the cycle after the strobe
	always @(posedge clk_sys) begin
		if (rd_seen) begin
			chk(reg_rdata, rd_q.pop_front());
		end
		rd_seen <= reg_rd & ce;
	end

	// baseline histogram stream and event stream watchers
	always @(posedge clk_sys) begin
		if (armed && bl_hist_valid) begin
			bl_cnt++;
			if (hist_zero) begin
				chk(bl_hist_value, 32'h0);
			end
		end
		if (armed && busy && !busy_q) begin
			t_b = cyc;
		end
		if (armed && !busy && busy_q && dur_chk) begin
			chk(cyc - t_b, pint);
		end
		if (armed && event_valid) begin
			lo = lo_q.pop_front();
			hi = hi_q.pop_front();
			chk((cyc - t_b >= lo) && (cyc - t_b <= hi), 1'b1);
			chk(event_energy > 0, 1'b1);
		end
		busy_q <= busy;
	end

	// main sequence
	initial begin
		void'($urandom(32'h5dfd));
		clks(10);
		rst <= 1'b0;
		// fill the unreset history memory with a flat input, then reset
		clks(1100);
		rst <= 1'b1;
		clks(10);
		rst <= 1'b0;
		armed = 1'b1;
		hist_zero = 1'b1;
		@(posedge clk_sys);
		wr(A_BL_DIV, 32'h200);
		wr(A_BL_PERIOD, 32'hffff);
		for (int i = 0; i < 11; i++) begin
			rd(4'(i), rst_tab[i]);
		end
		// divisor 512 asks for 32768/512 = 64 starting samples
		clks(50);
		chk(bl_cnt, 32'd64);
		rd(A_STATUS, 32'h20000);
		rd(A_BL_AVG, 32'h0);
		$display("test reset values and baseline start done");
		for (int i = 0; i < 4; i++) begin
			d = $urandom();
			wr(A_BL_CENTER, d);
			rd(A_BL_CENTER, d);
			wr(A_BL_CUT, ~d);
			rd(A_BL_CUT, ~d);
		end
		for (int a = 11; a < 16; a++) begin
			wr(4'(a), $urandom());
		end
		rd(A_ENERGY, 32'h0);
		rd(A_BL_AVG, 32'h0);
		rd(A_STATUS, 32'h20000);
		rd(4'he, 32'h0);
		rd(4'hf, 32'h0);
		ce <= 1'b0;
		wr(A_BL_CENTER, 32'h1);
		ce <= 1'b1;
		rd(A_BL_CENTER, d);
		wr(A_BL_CENTER, 32'h0);
		wr(A_BL_CUT, 32'h01000100);
		$display("test register access done");
		wr(A_BL_PERIOD, 32'h10);
		clks(20);
		bl_cnt = 0;
		clks(170);
		chk(bl_cnt >= 9 && bl_cnt <= 11, 1'b1);
		$display("test periodic baseline done");
		// leakage ramp gives a steady nonzero baseline, placed outside the cut
		hist_zero = 1'b0;
		wr(A_BL_CENTER, 32'h1000);
		ramp <= 1'b1;
		clks(300);
		rd(A_BL_AVG, 32'h0);
		chk(bl_hist_value != 0, 1'b1);
		level <= adc_data;
		ramp <= 1'b0;
		wr(A_BL_CENTER, 32'h0);
		clks(300);
		$display("test baseline cut done");
		// fixed delay sampling with a random delay below the peak interval
		wr(A_ENERGY_FILT, {16'h0, 8'h04, 8'h10});
		for (int i = 0; i < 3; i++) begin
			psd = 8'h10 + 8'($urandom_range(15));
			wr(A_PEAK, {16'h0, psd, pint});
			lo_q.push_back(psd);
			hi_q.push_back(psd);
			level <= level + 14'h400;
			clks(100);
		end
		rd(A_STATUS, 32'h20003);
		$display("test peak sampling done");
		// max capture in decimation 2, 4 and 6, intermediate trigger only
		dur_chk = 1'b0;
		for (int c = 1; c < 4; c++) begin
			f = 1 << (2 * c);
			wr(A_CTRL, 32'(c));
			wr(A_BL_DIV, (c == 1) ? 32'h100 : 32'h80);
			clks(40 * f);
			wr(A_CTRL, 32'h20 + 32'(c));
			lo_q.push_back(f * (pint - 1));
			hi_q.push_back(f * (pint + 1));
			level <= level + 14'h400;
			clks((pint + 10) * f);
		end
		rd(A_STATUS, 32'h20006);
		$display("test max capture done");
		end_of_test();
	end
endmodule : pbp_core_bench
